// [rtl/sra_consts.vh]
/*
  Constants for the sensor register bank: offsets, field positions,
  reset values and the auto-increment targets.
  Assumes it is included by bare name from the bank and its helper.
*/
`ifndef SRA_CONSTS_VH
`define SRA_CONSTS_VH

// documented offsets
`define SRA_OFF_STATUS     8'h00
`define SRA_OFF_X_HIGH     8'h01
`define SRA_OFF_X_LOW      8'h02
`define SRA_OFF_Y_HIGH     8'h03
`define SRA_OFF_Y_LOW      8'h04
`define SRA_OFF_Z_HIGH     8'h05
`define SRA_OFF_Z_LOW      8'h06
`define SRA_OFF_RSVD_LO    8'h07
`define SRA_OFF_RSVD_HI    8'h08
`define SRA_OFF_FIFO_SETUP 8'h09
`define SRA_OFF_FIFO_TRIG  8'h0a
`define SRA_OFF_SYS_MODE   8'h0b
`define SRA_OFF_INT_SRC    8'h0c
`define SRA_OFF_MAG_START  8'h33

// extra control and interrupt registers
`define SRA_OFF_CONTROL_ONE 8'h40
`define SRA_OFF_MAG_CTRL2   8'h41
`define SRA_OFF_IRQ_STATUS  8'h42
`define SRA_OFF_IRQ_MASK    8'h43

// field positions
`define SRA_FMODE_HI     7
`define SRA_FMODE_LO     6
`define SRA_FAST_READ    1
`define SRA_HYB_OPTION   5
`define SRA_SEL_HI       1
`define SRA_SEL_LO       0
`define SRA_SEL_HYBRID   2'h3

// interrupt event bits
`define SRA_EV_SAMPLE    0
`define SRA_EV_WRAP      1
`define SRA_EV_MAG_JUMP  2
`define SRA_EV_FIFO_READ 3
`define SRA_EV_BITS      4

// reset values
`define SRA_RST_BYTE     8'h00
`define SRA_RST_EVENTS   4'h0

`endif

// [rtl/sra_next_addr.v]
/*
  Auto-increment table: the offset a burst moves to after a byte.
  Assumes the caller gives the fifo, fast-read and hybrid selections
  already decoded to single bits.
*/
`timescale 1ns/10ps
`include "sra_consts.vh"

module sra_next_addr (
  // current byte and mode
  input  wire [7:0] cur,
  input  wire       fifo_on,
  input  wire       fast_read,
  input  wire       hyb_jump,
  // next offset
  output reg  [7:0] nxt
);

  // end of acceleration data: back to zero or on to the magnetics
  wire [7:0] z_end;

  assign z_end = hyb_jump ? `SRA_OFF_MAG_START : `SRA_OFF_STATUS;

  // table lookup, everything unlisted simply steps by one
  always @* begin
    nxt = cur + 8'h01;
    case (cur)
      `SRA_OFF_STATUS: nxt = `SRA_OFF_X_HIGH;
      `SRA_OFF_X_HIGH: begin
        if (fifo_on)
          nxt = `SRA_OFF_X_HIGH; // fifo drains through one byte
        else if (fast_read)
          nxt = `SRA_OFF_Y_HIGH;
        else
          nxt = `SRA_OFF_X_LOW;
      end
      `SRA_OFF_X_LOW: nxt = fast_read ? `SRA_OFF_STATUS : `SRA_OFF_Y_HIGH;
      `SRA_OFF_Y_HIGH: begin
        if (!fast_read)
          nxt = `SRA_OFF_Y_LOW;
        else if (fifo_on)
          nxt = `SRA_OFF_STATUS;
        else
          nxt = `SRA_OFF_Z_HIGH;
      end
      `SRA_OFF_Y_LOW: nxt = fast_read ? `SRA_OFF_STATUS : `SRA_OFF_Z_HIGH;
      `SRA_OFF_Z_HIGH: nxt = fast_read ? z_end : `SRA_OFF_Z_LOW;
      `SRA_OFF_Z_LOW: nxt = z_end;
      `SRA_OFF_RSVD_LO: nxt = `SRA_OFF_RSVD_HI;
      `SRA_OFF_RSVD_HI: nxt = `SRA_OFF_FIFO_SETUP;
      `SRA_OFF_FIFO_TRIG: nxt = `SRA_OFF_SYS_MODE;
      default: nxt = cur + 8'h01;
    endcase
  end

endmodule // sra_next_addr

// [rtl/sra_reg_bank.v]
/*
  Lower register bank of the motion and magnetic sensor: status,
  acceleration bytes, fifo setup and trigger, system mode, interrupt
  source, plus burst pointer and a small interrupt block.
  Assumes sample, fifo and mode inputs are synchronous to clk, and a
  serial front end that turns each transferred byte into one strobe.
*/
`timescale 1ns/10ps
`include "sra_consts.vh"

module sra_reg_bank #(
  parameter SAMPLE_W = 14 // acceleration sample width
) (
  // clock and reset
  input  wire                clk,
  input  wire                arst_n,
  // register port
  input  wire [7:0]          addr,
  input  wire [7:0]          wdata,
  input  wire                wr,
  input  wire                rd,
  input  wire                seq_rd,
  output reg  [7:0]          rdata_r,
  // sensor side
  input  wire [SAMPLE_W-1:0] accel_x,
  input  wire [SAMPLE_W-1:0] accel_y,
  input  wire [SAMPLE_W-1:0] accel_z,
  input  wire                sample_strobe,
  input  wire [7:0]          data_ready_flags,
  input  wire [7:0]          fifo_status,
  input  wire [7:0]          fifo_byte,
  input  wire [7:0]          sys_mode,
  input  wire [7:0]          int_source,
  // outputs to the rest of the sensor
  output reg                 fifo_pop_r,
  output reg  [7:0]          fifo_trig_r,
  output reg  [7:0]          ptr_r,
  output reg                 irq_r
);

  // software visible storage
  reg  [7:0]              fifo_setup_r;   // fifo mode and watermark
  reg  [7:0]              control_one_r;  // fast read bit lives here
  reg  [7:0]              mag_ctrl_r;     // hybrid option and sensor select
  reg  [7:0]              status_r;       // snapshot for offset zero
  reg  [`SRA_EV_BITS-1:0] ev_stat_r;      // sticky interrupt status
  reg  [`SRA_EV_BITS-1:0] ev_mask_r;      // interrupt enables
  reg  [`SRA_EV_BITS-1:0] ev_stat_nxt;    // next sticky status
  reg  [7:0]              rdata_nxt;      // next read data
  reg  [7:0]              rd_addr;        // offset being read this cycle

  // decoded mode bits
  wire                    fifo_on;        // fifo mode field nonzero
  wire                    fast_read;      // low bytes are skipped
  wire                    hyb_mode;       // both sensors alternate
  wire                    hyb_jump;       // burst continues into magnetics
  wire                    any_rd;         // either kind of read
  wire [7:0]              nxt_addr;       // auto-increment target

  // padded low bytes, the two spare bits read zero
  wire [7:0]              x_high;
  wire [7:0]              x_low;
  wire [7:0]              y_high;
  wire [7:0]              y_low;
  wire [7:0]              z_high;
  wire [7:0]              z_low;

  // field decode
  assign fifo_on   = |fifo_setup_r[`SRA_FMODE_HI:`SRA_FMODE_LO];
  assign fast_read = control_one_r[`SRA_FAST_READ];
  // only a true hybrid setting enables the jump to the magnetics
  assign hyb_mode  = (mag_ctrl_r[`SRA_SEL_HI:`SRA_SEL_LO] == `SRA_SEL_HYBRID);
  assign hyb_jump  = mag_ctrl_r[`SRA_HYB_OPTION] & hyb_mode;
  assign any_rd    = rd | seq_rd;

  // sample slicing: high byte is the top eight bits
  assign x_high = accel_x[SAMPLE_W-1:SAMPLE_W-8];
  assign x_low  = {accel_x[SAMPLE_W-9:0], 2'h0};
  assign y_high = accel_y[SAMPLE_W-1:SAMPLE_W-8];
  assign y_low  = {accel_y[SAMPLE_W-9:0], 2'h0};
  assign z_high = accel_z[SAMPLE_W-1:SAMPLE_W-8];
  assign z_low  = {accel_z[SAMPLE_W-9:0], 2'h0};

  // which offset is read: the strobe address or the burst pointer
  always @* begin
    if (rd)
      rd_addr = addr;
    else
      rd_addr = ptr_r;
  end

  // auto-increment table
  sra_next_addr u_next (
    .cur       (rd_addr),
    .fifo_on   (fifo_on),
    .fast_read (fast_read),
    .hyb_jump  (hyb_jump),
    .nxt       (nxt_addr)
  );

  // read mux, unmapped offsets answer zero
  always @* begin
    rdata_nxt = `SRA_RST_BYTE;
    case (rd_addr)
      `SRA_OFF_STATUS:      rdata_nxt = status_r;
      `SRA_OFF_X_HIGH: begin
        if (fifo_on)
          rdata_nxt = fifo_byte;
        else
          rdata_nxt = x_high;
      end
      `SRA_OFF_X_LOW:       rdata_nxt = x_low;
      `SRA_OFF_Y_HIGH:      rdata_nxt = y_high;
      `SRA_OFF_Y_LOW:       rdata_nxt = y_low;
      `SRA_OFF_Z_HIGH:      rdata_nxt = z_high;
      `SRA_OFF_Z_LOW:       rdata_nxt = z_low;
      `SRA_OFF_RSVD_LO:     rdata_nxt = `SRA_RST_BYTE;
      `SRA_OFF_RSVD_HI:     rdata_nxt = `SRA_RST_BYTE;
      `SRA_OFF_FIFO_SETUP:  rdata_nxt = fifo_setup_r;
      `SRA_OFF_FIFO_TRIG:   rdata_nxt = fifo_trig_r;
      `SRA_OFF_SYS_MODE:    rdata_nxt = sys_mode;
      `SRA_OFF_INT_SRC:     rdata_nxt = int_source;
      `SRA_OFF_CONTROL_ONE: rdata_nxt = control_one_r;
      `SRA_OFF_MAG_CTRL2:   rdata_nxt = mag_ctrl_r;
      `SRA_OFF_IRQ_STATUS:  rdata_nxt = {4'h0, ev_stat_r};
      `SRA_OFF_IRQ_MASK:    rdata_nxt = {4'h0, ev_mask_r};
      default:              rdata_nxt = `SRA_RST_BYTE;
    endcase
  end

  // read data register, valid only in the cycle after a strobe
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_r <= `SRA_RST_BYTE;
    end else if (any_rd) begin
      rdata_r <= rdata_nxt;
    end else begin
      rdata_r <= `SRA_RST_BYTE; // zero between reads keeps traces clean
    end
  end

  // burst pointer: every byte read moves it along the table
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ptr_r <= `SRA_OFF_STATUS;
    end else if (any_rd) begin
      ptr_r <= nxt_addr;
    end
  end

  // status snapshot: ready flags, or fifo status once the fifo runs
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status_r <= `SRA_RST_BYTE;
    end else if (fifo_on) begin
      status_r <= fifo_status;
    end else begin
      status_r <= data_ready_flags;
    end
  end

  // fifo pop: each x high byte read in fifo mode consumes one byte
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fifo_pop_r <= 1'b0;
    end else begin
      fifo_pop_r <= any_rd & fifo_on & (rd_addr == `SRA_OFF_X_HIGH);
    end
  end

  // writable registers; read-only offsets ignore writes
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fifo_setup_r  <= `SRA_RST_BYTE;
      fifo_trig_r   <= `SRA_RST_BYTE;
      control_one_r <= `SRA_RST_BYTE;
      mag_ctrl_r    <= `SRA_RST_BYTE;
      ev_mask_r     <= `SRA_RST_EVENTS;
    end else if (wr) begin
      case (addr)
        `SRA_OFF_FIFO_SETUP:  fifo_setup_r  <= wdata;
        `SRA_OFF_FIFO_TRIG:   fifo_trig_r   <= wdata;
        `SRA_OFF_CONTROL_ONE: control_one_r <= wdata;
        `SRA_OFF_MAG_CTRL2:   mag_ctrl_r    <= wdata;
        `SRA_OFF_IRQ_MASK:    ev_mask_r     <= wdata[`SRA_EV_BITS-1:0];
        default: begin
          // read-only, unmapped or the interrupt status (cleared elsewhere), nothing stored
        end
      endcase
    end
  end

  // sticky events: a new event in the clearing cycle survives
  always @* begin
    ev_stat_nxt = ev_stat_r;
    if (wr && (addr == `SRA_OFF_IRQ_STATUS))
      ev_stat_nxt = ev_stat_nxt & ~wdata[`SRA_EV_BITS-1:0];
    // sets applied after the clear so they win
    if (sample_strobe)
      ev_stat_nxt[`SRA_EV_SAMPLE] = 1'b1;
    // only the end of the acceleration bytes counts, not a pointer rollover
    if (any_rd && (nxt_addr == `SRA_OFF_STATUS) && (rd_addr < `SRA_OFF_RSVD_LO))
      ev_stat_nxt[`SRA_EV_WRAP] = 1'b1;
    if (any_rd && (nxt_addr == `SRA_OFF_MAG_START) && (rd_addr < `SRA_OFF_RSVD_LO))
      ev_stat_nxt[`SRA_EV_MAG_JUMP] = 1'b1;
    if (any_rd && fifo_on && (rd_addr == `SRA_OFF_X_HIGH))
      ev_stat_nxt[`SRA_EV_FIFO_READ] = 1'b1;
  end

  // status register and level interrupt, both from flops
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ev_stat_r <= `SRA_RST_EVENTS;
      irq_r     <= 1'b0;
    end else begin
      ev_stat_r <= ev_stat_nxt;
      irq_r     <= |(ev_stat_nxt & ev_mask_r);
    end
  end

endmodule // sra_reg_bank

// [tb/sra_host.sv]
/*
  Host model: the serial front end's view, one register byte per strobe.
  Assumes the bank answers a read in the next cycle and never stalls.
*/
`timescale 1ns/10ps
module sra_host (
  // clock and answer
  input  wire       clk,
  input  wire [7:0] rdata_r,
  // register port
  output reg  [7:0] addr   = 8'h00,
  output reg  [7:0] wdata  = 8'h00,
  output reg        wr     = 1'b0,
  output reg        rd     = 1'b0,
  output reg        seq_rd = 1'b0
);
  reg [7:0] bq [0:15]; // bytes of the last burst
  // one write cycle; bus lines flipped after so stale values never match
  task wr_b(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
      addr  <= ~a;
      wdata <= ~d;
    end
  endtask
  // burst of n bytes: addressed read, then pointer reads back to back
  task rd_burst(input [7:0] a, input integer n);
    integer i;
    begin
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      for (i = 0; i < n; i = i + 1) begin
        @(posedge clk);
        rd     <= 1'b0;
        seq_rd <= (i < n - 1);
        addr   <= ~a;
        @(negedge clk);
        bq[i] = rdata_r; // answer stands one cycle only
      end
    end
  endtask
endmodule // sra_host

// [tb/sra_reg_bank_assertions.sv]
/*
  Port checker for the sensor register bank, bound onto sra_reg_bank.
  Assumes one clock domain and read data one cycle after a strobe.
*/
`timescale 1ns/10ps
module sra_chk (
  // clock and reset
  input wire       clk,
  input wire       arst_n,
  // register port
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire       wr,
  input wire       rd,
  input wire       seq_rd,
  input wire [7:0] rdata_r,
  // sensor side
  input wire [7:0] fifo_byte,
  input wire [7:0] sys_mode,
  // bank outputs
  input wire       fifo_pop_r,
  input wire [7:0] fifo_trig_r,
  input wire [7:0] ptr_r
);
  wire       tk  = rd | seq_rd;       // a read is taken
  wire [7:0] cur = rd ? addr : ptr_r; // offset being read, rd wins
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  idle_zero_a: assert property (!tk |=> rdata_r == 8'h00)
    else $error("read data not zero when idle");
  stat_next_a: assert property (tk && cur == 8'h00 |=> ptr_r == 8'h01)
    else $error("status not followed by x high");
  fifo_data_a: assert property (fifo_pop_r |-> rdata_r == $past(fifo_byte))
    else $error("fifo byte not returned");
  fast_skip_a: assert property (tk && cur == 8'h03 |=> ptr_r inside {8'h00, 8'h04, 8'h05})
    else $error("bad step after y high");
  z_end_a: assert property (tk && cur == 8'h06 |=> ptr_r == 8'h00 || ptr_r == 8'h33)
    else $error("bad step after z low");
  rsvd_zero_a: assert property (tk && (cur == 8'h07 || cur == 8'h08)
    |=> rdata_r == 8'h00 && ptr_r == $past(cur) + 8'h01)
    else $error("reserved byte wrong");
  trig_wr_a: assert property (wr && addr == 8'h0a |=> fifo_trig_r == $past(wdata))
    else $error("trigger select not written");
  trig_rd_a: assert property (tk && cur == 8'h0a |=> ptr_r == 8'h0b && rdata_r == fifo_trig_r)
    else $error("trigger select read wrong");
  mode_rd_a: assert property (tk && cur == 8'h0b |=> ptr_r == 8'h0c && rdata_r == $past(sys_mode))
    else $error("system mode read wrong");
endmodule // sra_chk

bind sra_reg_bank sra_chk u_chk (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .seq_rd(seq_rd), .rdata_r(rdata_r), .fifo_byte(fifo_byte),
  .sys_mode(sys_mode), .fifo_pop_r(fifo_pop_r), .fifo_trig_r(fifo_trig_r), .ptr_r(ptr_r));

// [tb/tb_sra_reg_bank.sv]
/*
  Self-checking bench for the sensor register bank.
  Assumes sra_host drives the register port and sra_chk is bound.
*/
`timescale 1ns/10ps
module tb_sra_reg_bank;
  // clock, reset and sensor inputs
  reg         clk;
  reg         arst_n;
  reg  [13:0] ax, ay, az;
  reg         strobe;
  reg  [7:0]  drf, fst, fb, sm, isrc;
  // register port and outputs
  wire [7:0]  addr, wdata, rdata_r, trig, ptr;
  wire        wr, rd, seq_rd, pop, irq;
  // bench state: mode bits as the bench believes them
  integer     miscompares, num_checks, i, k;
  integer     pops, pops_exp; // fifo pops seen and expected
  reg         fon, fast, hj;
  reg  [7:0]  fset, tval, p;

  sra_reg_bank u_dut (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .seq_rd(seq_rd), .rdata_r(rdata_r), .accel_x(ax), .accel_y(ay), .accel_z(az),
    .sample_strobe(strobe), .data_ready_flags(drf), .fifo_status(fst), .fifo_byte(fb),
    .sys_mode(sm), .int_source(isrc), .fifo_pop_r(pop), .fifo_trig_r(trig), .ptr_r(ptr),
    .irq_r(irq));
  sra_host u_host (.clk(clk), .rdata_r(rdata_r), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .seq_rd(seq_rd));

  // pop is high one cycle per byte popped, so back-to-back pops hold it high; counted each cycle away from the launching edge
  always @(negedge clk) begin
    if (pop === 1'b1)
      pops = pops + 1;
  end

  // expected pointer step, per the increment table
  function [7:0] nxt(input [7:0] a);
    case (a)
      8'h01:   nxt = fon ? 8'h01 : (fast ? 8'h03 : 8'h02);
      8'h02:   nxt = fast ? 8'h00 : 8'h03;
      8'h03:   nxt = !fast ? 8'h04 : (fon ? 8'h00 : 8'h05);
      8'h04:   nxt = fast ? 8'h00 : 8'h05;
      8'h05:   nxt = fast ? (hj ? 8'h33 : 8'h00) : 8'h06;
      8'h06:   nxt = hj ? 8'h33 : 8'h00;
      default: nxt = a + 8'h01;
    endcase
  endfunction
  // expected byte at an offset
  function [7:0] dat(input [7:0] a);
    case (a)
      8'h00:   dat = fon ? fst : drf;
      8'h01:   dat = fon ? fb : ax[13:6];
      8'h02:   dat = {ax[5:0], 2'b00};
      8'h03:   dat = ay[13:6];
      8'h04:   dat = {ay[5:0], 2'b00};
      8'h05:   dat = az[13:6];
      8'h06:   dat = {az[5:0], 2'b00};
      8'h09:   dat = fset;
      8'h0a:   dat = tval;
      8'h0b:   dat = sm;
      8'h0c:   dat = isrc;
      default: dat = 8'h00; // reserved and unmapped
    endcase
  endfunction

  task check(input [7:0] got, input [7:0] exp, input string what);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("CHECK FAILED at %0t: %0s got %h want %h", $time, what, got, exp);
      end
    end
  endtask
  // burst from a, each byte outside 8'h33 to 8'h3f and the final pointer compared
  task burst_chk(input [7:0] a, input integer n);
    begin
      u_host.rd_burst(a, n);
      p = a;
      for (k = 0; k < n; k = k + 1) begin
        if (p < 8'h33 || p > 8'h3f) check(u_host.bq[k], dat(p), "burst byte");
        if (p == 8'h01 && fon) pops_exp = pops_exp + 1;
        p = nxt(p);
      end
      check(ptr, p, "pointer");
    end
  endtask
  // new random sensor values; one spare edge for the flag snapshot
  task rnd;
    begin
      @(posedge clk);
      {ax, ay, az} <= 42'({$urandom, $urandom});
      {drf, fst, fb, sm, isrc} <= 40'({$urandom, $urandom});
      @(posedge clk);
    end
  endtask
  task irq_wait(input e);
    begin
      repeat (4) if (irq !== e) @(negedge clk);
      check({7'h00, irq}, {7'h00, e}, "irq level");
    end
  endtask
  task summarize;
    begin
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask

  // free-running 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    miscompares = miscompares + 1;
    summarize;
  end
  // main sequence
  initial begin
    {arst_n, strobe, fon, fast, hj, ax, ay, az} = 0;
    {drf, fst, fb, sm, isrc, fset, tval} = 0;
    miscompares = 0;
    pops = 0;
    pops_exp = 0;
    num_checks = 0;
    k = $urandom(32'h9e6c);
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    burst_chk(8'h00, 2);
    burst_chk(8'h09, 2);
    $display("reset values done");
    for (i = 0; i < 16; i = i + 1) begin
      fon  = i[0] | i[3];
      fast = i[1];
      hj   = i[2];
      fset = {i[0], i[3], 6'h11};
      tval = 8'($urandom);
      u_host.wr_b(8'h09, fset);
      u_host.wr_b(8'h0a, tval);
      u_host.wr_b(8'h40, {6'h00, fast, 1'b0});
      u_host.wr_b(8'h41, hj ? 8'h23 : (i[3] ? 8'h20 : 8'h03));
      rnd;
      check(trig, tval, "trigger copy");
      burst_chk(8'h00, 10);
      burst_chk(8'h05, 3);
      burst_chk(8'h07, 7);
    end
    check(pops[7:0], pops_exp[7:0], "fifo pops");
    $display("burst modes done");
    u_host.wr_b(8'h0b, ~sm);
    burst_chk(8'h0b, 1);
    burst_chk(8'h20, 1);
    $display("refused access done");
    u_host.wr_b(8'h42, 8'h0f);
    u_host.wr_b(8'h43, 8'h01);
    irq_wait(1'b0);
    @(posedge clk) strobe <= 1'b1;
    @(posedge clk) strobe <= 1'b0;
    irq_wait(1'b1);
    u_host.wr_b(8'h43, 8'h00);
    irq_wait(1'b0);
    u_host.wr_b(8'h43, 8'h01);
    irq_wait(1'b1);
    // new event in the clearing cycle: the set must win
    fork
      u_host.wr_b(8'h42, 8'h01);
      begin
        @(posedge clk) strobe <= 1'b1;
        @(posedge clk) strobe <= 1'b0;
      end
    join
    @(negedge clk);
    irq_wait(1'b1);
    u_host.wr_b(8'h42, 8'h01);
    irq_wait(1'b0);
    $display("interrupt done");
    // mid-run reset: outputs and registers back to their reset values
    @(posedge clk) arst_n <= 1'b0;
    @(negedge clk);
    check(ptr, 8'h00, "reset pointer");
    check(trig, 8'h00, "reset trigger");
    check({7'h00, irq}, 8'h00, "reset irq");
    {fon, fast, hj, fset, tval} = 0;
    @(posedge clk) arst_n <= 1'b1;
    burst_chk(8'h09, 2);
    burst_chk(8'h00, 2);
    $display("mid-run reset done");
    summarize;
  end
endmodule // tb_sra_reg_bank
